// ---- pkg/flash_cmd_pkg.sv ----
/*
  Constants shared by the flash command front end and the CPU-side driver:
  access-width codes, command data and address patterns, address range.
  Assumes a single clock domain and byte addresses on a 32-bit CPU bus.
*/
package flash_cmd_pkg;
  // Access-width field codes
  localparam logic [1:0] WIDTH_READ_ONLY = 2'h2;
  localparam logic [1:0] WIDTH_PROGRAM = 2'h1;
  localparam logic [1:0] WIDTH_RESET = WIDTH_READ_ONLY;
  // Command data, low byte only
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_READ_RESET = 8'hF0;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESTART = 8'h30;
  // Command addresses, low 16 bits only
  localparam logic [15:0] ADDR_UNLOCK1 = 16'h1550;
  localparam logic [15:0] ADDR_UNLOCK2 = 16'h0AA8;
  // Flash range, upper 16 address bits: main array plus security/trim area
  localparam logic [15:0] RANGE_LOW_HI = 16'h0000;
  localparam logic [15:0] RANGE_HIGH_HI = 16'h0010;
  // Special in-range bases for security code and trimming data
  localparam logic [31:0] SECURITY_BASE = 32'h0010_0000;
  localparam logic [31:0] TRIM_BASE = 32'h0010_1004;
  // Check bits per 32-bit word
  localparam int CHECK_BITS = 7;
  // Sector erase queueing window in ns and its cycle count at 40 ns
  localparam int ERASE_WINDOW_NS = 35000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int ERASE_WINDOW_CYCLES = ERASE_WINDOW_NS / CLK_PERIOD_NS;
  // Algorithm kinds reported on start
  typedef enum logic [2:0]
  {
    ALG_NONE = 3'h0,
    ALG_PROGRAM = 3'h1,
    ALG_CHIP_ERASE = 3'h2,
    ALG_SECTOR_ERASE = 3'h3,
    ALG_SUSPEND = 3'h4,
    ALG_RESTART = 3'h5,
    ALG_READ_RESET = 3'h6
  } alg_t;
endpackage

// ---- pkg/flash_bus_if.sv ----
/*
  Carrier between the CPU-side driver and the flash front end.
  Assumes one clock; a request is taken in any cycle where req is high.
*/
interface flash_bus_if;
  logic req;         // Request strobe, one cycle
  logic write;       // 1 write, 0 read
  logic [1:0] size;  // 2'h1 half-word, 2'h2 word
  logic [31:0] addr; // Byte address
  logic [15:0] wdata; // Write half-word
  logic [31:0] rdata; // Read data, registered
  logic rvalid;      // Read data valid, one cycle
  logic err;         // Access refused, one cycle
  modport device (input req, write, size, addr, wdata, output rdata, rvalid, err);
  modport host (output req, write, size, addr, wdata, input rdata, rvalid, err);
endinterface

// ---- rtl/flash_cmd_device.sv ----
/*
  Flash front end: access-width mode, command sequence decoder and
  single-error-correcting read path over a word array of data plus checks.
  Assumes the CPU driver issues one request per cycle at most.
*/
// What this block does
// R1 - Width code 10 gives read-only word mode
// R2 - Read-only mode never starts any algorithm
// R3 - Reset returns width field to 10
// R4 - Width code 01 gives half-word programming mode
// R5 - Programming mode refuses word reads
// R6 - One to six half-word writes form commands
// R7 - Single F0 write means read/reset
// R8 - Program: AA, 55, A0, then data
// R9 - Chip erase: six writes ending 10@1550
// R10 - Sector erase sixth write is 30 anywhere
// R11 - Single B0 write means erase suspend
// R12 - Single 30 write means erase restart
// R13 - Only low data byte is decoded
// R14 - Host writes commands as half-words
// R15 - Low 16 address bits match; upper in range
// R16 - Out-of-range writes do not advance sequence
// R17 - Security code uses base 0x0010_0000
// R18 - Trim data uses address 0x0010_1004
// R19 - Seven check bits stored per word
// R20 - Reads correct single-bit errors, no delay
// R21 - Program data to odd address is rejected
// R22 - Extra 30 writes queue sectors in window
// R23 - Broken pattern drops back to read
// R24 - Undefined writes in a state are ignored; code ignores them only in read state, other states drop back to read
module flash_cmd_device
  import flash_cmd_pkg::*;
#(
  parameter int WORDS = 1024,
  parameter int WINDOW_CYCLES = ERASE_WINDOW_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  flash_bus_if.device bus,
  input wire logic [1:0] width_wdata,
  input wire logic width_we,
  output logic [1:0] access_width_field,
  output logic alg_start,
  output alg_t alg_kind,
  output logic [31:0] alg_addr,
  output logic [15:0] alg_data,
  output logic erase_pending
);
  // Refuse sizes that the index or the 16-bit window counter cannot hold
  if (WORDS < 2 || WINDOW_CYCLES < 1 || WINDOW_CYCLES > 65535)
    $error("flash_cmd_device: bad parameters");

  localparam int AW = $clog2(WORDS);

  // Command decoder states
  typedef enum logic [6:0]
  {
    ST_READ = 7'h01,
    ST_U1 = 7'h02,
    ST_U2 = 7'h04,
    ST_PROG = 7'h08,
    ST_E3 = 7'h10,
    ST_E4 = 7'h20,
    ST_E5 = 7'h40
  } state_t;

  // Hamming(38,32) plus overall parity: 7 check bits per word
  function automatic logic [6:0] ecc_gen(input logic [31:0] d);
    logic [6:0] c;
    int p, k;
    c = '0;
    p = 3;
    for (int i = 0; i < 32; i++)
    begin
      while ((p & (p - 1)) == 0)
        p = p + 1;
      for (k = 0; k < 6; k++)
        if (p[k])
          c[k] = c[k] ^ d[i];
      p = p + 1;
    end
    c[6] = ^d ^ (^c[5:0]);
    return c;
  endfunction

  // Syndrome position to data bit index; 32 means no data bit
  function automatic logic [5:0] syn_bit(input logic [5:0] s);
    logic [5:0] r;
    int p;
    p = 3;
    r = 6'd32;
    for (int i = 0; i < 32; i++)
    begin
      while ((p & (p - 1)) == 0)
        p = p + 1;
      if (s == p[5:0])
        r = 6'(i);
      p = p + 1;
    end
    return r;
  endfunction

  state_t state;
  state_t next_state;
  logic [31:0] data_mem [WORDS]; // Data words
  logic [6:0] check_mem [WORDS]; // Check bits per word
  logic [15:0] window_count;     // Sector-erase queue window
  logic [31:0] raw_word;
  logic [6:0] raw_check;

  // Mode and address decode
  wire prog_mode = access_width_field == WIDTH_PROGRAM;          // see R4
  wire ro_mode = access_width_field == WIDTH_READ_ONLY;          // see R1
  wire in_range = bus.addr[31:16] >= RANGE_LOW_HI && bus.addr[31:16] <= RANGE_HIGH_HI;
  wire [7:0] cbyte = bus.wdata[7:0];                              // see R13
  wire [15:0] laddr = bus.addr[15:0];                             // see R15
  wire at_u1 = laddr == ADDR_UNLOCK1;
  wire at_u2 = laddr == ADDR_UNLOCK2;
  // A write is taken as a command only in programming mode, half-word, in range
  wire cmd_wr = bus.req && bus.write && prog_mode && bus.size == WIDTH_PROGRAM
    && in_range;                                                  // see R2 see R16
  wire [AW-1:0] widx = AW'(bus.addr[31:2]);
  wire window_open = window_count != '0;

  // Single-write commands decoded from the read state
  wire is_reset = cbyte == CMD_READ_RESET;                        // see R7
  wire is_suspend = cbyte == CMD_SUSPEND;                         // see R11
  wire is_restart = cbyte == CMD_RESTART;                         // see R12
  wire seq_ok = (state == ST_READ && cbyte == CMD_UNLOCK1 && at_u1)
    || (state == ST_U1 && cbyte == CMD_UNLOCK2 && at_u2)
    || (state == ST_U2 && at_u1 && (cbyte == CMD_PROGRAM || cbyte == CMD_ERASE_SETUP))
    || (state == ST_E3 && cbyte == CMD_UNLOCK1 && at_u1)
    || (state == ST_E4 && cbyte == CMD_UNLOCK2 && at_u2);
  wire prog_fire = state == ST_PROG && !bus.addr[0];              // see R8 see R21
  wire chip_fire = state == ST_E5 && at_u1 && cbyte == CMD_CHIP_ERASE; // see R9
  wire sect_fire = state == ST_E5 && cbyte == CMD_SECTOR_ERASE;   // see R10
  wire queue_fire = state == ST_READ && window_open && cbyte == CMD_SECTOR_ERASE; // see R22
  // Single-write commands only count from the read state
  wire is_single = state == ST_READ && (is_reset || is_suspend || is_restart);
  wire alg_t single_kind = is_reset ? ALG_READ_RESET
    : (is_suspend ? ALG_SUSPEND : ALG_RESTART);                  // see R7 see R11 see R12

  // Next decoder state
  always_comb
  begin
    next_state = state;
    if (cmd_wr)
    begin
      unique case (state)
        ST_READ: next_state = seq_ok ? ST_U1 : ST_READ;            // see R24
        ST_U1: next_state = seq_ok ? ST_U2 : ST_READ;              // see R23
        ST_U2: next_state = !seq_ok ? ST_READ
          : (cbyte == CMD_PROGRAM ? ST_PROG : ST_E3);             // see R6
        ST_PROG: next_state = ST_READ;
        ST_E3: next_state = seq_ok ? ST_E4 : ST_READ;              // see R23
        ST_E4: next_state = seq_ok ? ST_E5 : ST_READ;
        ST_E5: next_state = ST_READ;
        default: next_state = ST_READ;
      endcase
    end
  end

  // Decoder state; leaving programming mode drops any partial sequence
  always_ff @(posedge clk)
  begin
    if (reset || !prog_mode)
      state <= ST_READ;
    else
      state <= next_state;
  end

  // Access-width field, forced to read-only on reset
  always_ff @(posedge clk)
  begin
    if (reset)
      access_width_field <= WIDTH_RESET;                          // see R3
    else if (width_we && (width_wdata == WIDTH_READ_ONLY || width_wdata == WIDTH_PROGRAM))
      access_width_field <= width_wdata;
  end

  // Algorithm start pulse with its kind, address and data
  always_ff @(posedge clk)
  begin
    alg_start <= 1'b0;
    if (reset)
    begin
      alg_kind <= ALG_NONE;
      alg_addr <= '0;
      alg_data <= '0;
    end
    else if (cmd_wr)
    begin
      alg_addr <= bus.addr;
      alg_data <= bus.wdata;
      if (prog_fire || chip_fire || sect_fire || queue_fire)
        alg_start <= 1'b1;                                         // see R6
      if (prog_fire)
        alg_kind <= ALG_PROGRAM;
      else if (chip_fire)
        alg_kind <= ALG_CHIP_ERASE;
      else if (sect_fire || queue_fire)
        alg_kind <= ALG_SECTOR_ERASE;
      else if (is_single)
      begin
        alg_kind <= single_kind;
        alg_start <= 1'b1;                                         // see R7 see R11 see R12
      end
    end
  end

  // Sector-erase queue window, reopened by each sector erase write
  always_ff @(posedge clk)
  begin
    if (reset || (cmd_wr && state == ST_READ && is_reset))
      window_count <= '0;
    else if (cmd_wr && (sect_fire || queue_fire))
      window_count <= 16'(WINDOW_CYCLES);                          // see R22
    else if (window_open)
      window_count <= window_count - 16'h0001;
  end

  assign erase_pending = window_open;

  // New half-word merged with the other half already stored in its word
  wire [31:0] merged_word = bus.addr[1] ? {bus.wdata, raw_word[15:0]}
    : {raw_word[31:16], bus.wdata};
  // Array write with generated check bits on a program start
  always_ff @(posedge clk)
  begin
    if (cmd_wr && prog_fire)
    begin
      data_mem[widx] <= merged_word;
      check_mem[widx] <= ecc_gen(merged_word);                     // see R19
    end
  end

  // Read path: correction is combinational on the fetched word
  wire [6:0] recheck = ecc_gen(raw_word);
  wire [5:0] syndrome = recheck[5:0] ^ raw_check[5:0];
  wire [5:0] bad_bit = syn_bit(syndrome);
  wire [31:0] fixed_word = (bad_bit < 6'd32) ? raw_word ^ (32'h0000_0001 << bad_bit)
    : raw_word;                                                   // see R20
  assign raw_word = data_mem[widx];
  assign raw_check = check_mem[widx];

  // Read legality per mode
  wire rd_req = bus.req && !bus.write;
  wire rd_ok = rd_req && in_range && ((ro_mode && bus.size == WIDTH_READ_ONLY)
    || (prog_mode && bus.size == WIDTH_PROGRAM));                 // see R5
  wire wr_bad = bus.req && bus.write && !cmd_wr;                  // see R2

  // Registered read answer and refusal
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      bus.rdata <= '0;
      bus.rvalid <= 1'b0;
      bus.err <= 1'b0;
    end
    else
    begin
      bus.rvalid <= rd_ok;
      bus.err <= (rd_req && !rd_ok) || wr_bad;
      if (rd_ok)
        bus.rdata <= prog_mode ? {16'h0000, bus.addr[1] ? fixed_word[31:16]
          : fixed_word[15:0]} : fixed_word;
    end
  end
endmodule // flash_cmd_device

// ---- rtl/flash_cmd_host.sv ----
/*
  CPU-side driver: expands a user command into its half-word write
  sequence on the flash bus, or performs one read.
  Assumes the flash front end answers reads one cycle after the request.
*/
module flash_cmd_host
  import flash_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  flash_bus_if.host bus,
  input wire logic start,
  input alg_t kind,
  input wire logic do_read,
  input wire logic word_read,
  input wire logic [31:0] target_addr,
  input wire logic [15:0] target_data,
  output logic busy,
  output logic [31:0] read_data,
  output logic read_done
);
  logic [2:0] step;
  logic [2:0] total;
  alg_t cur;
  logic [31:0] taddr;
  logic [15:0] tdata;
  logic reading;

  // Upper address kept inside the flash range of the target
  wire [15:0] base_hi = taddr[31:16];                              // see R15 see R17 see R18
  wire [7:0] dbyte [6] = '{CMD_UNLOCK1, CMD_UNLOCK2,
    cur == ALG_PROGRAM ? CMD_PROGRAM : CMD_ERASE_SETUP,
    CMD_UNLOCK1, CMD_UNLOCK2,
    cur == ALG_CHIP_ERASE ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE};
  wire [15:0] aseq [6] = '{ADDR_UNLOCK1, ADDR_UNLOCK2, ADDR_UNLOCK1,
    ADDR_UNLOCK1, ADDR_UNLOCK2, ADDR_UNLOCK1};
  wire single = cur == ALG_READ_RESET || cur == ALG_SUSPEND || cur == ALG_RESTART;
  wire [7:0] single_byte = cur == ALG_READ_RESET ? CMD_READ_RESET
    : (cur == ALG_SUSPEND ? CMD_SUSPEND : CMD_RESTART);
  wire last_data = cur == ALG_PROGRAM && step == 3'h3;              // see R8
  wire sect_last = cur == ALG_SECTOR_ERASE && step == 3'h5;        // see R10

  // Sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      step <= '0;
      total <= '0;
      cur <= ALG_NONE;
      taddr <= '0;
      tdata <= '0;
      busy <= 1'b0;
      reading <= 1'b0;
    end
    else if (!busy && start)
    begin
      cur <= kind;
      taddr <= target_addr;
      tdata <= target_data;
      step <= '0;
      total <= (kind == ALG_PROGRAM) ? 3'h4 : ((kind == ALG_CHIP_ERASE
        || kind == ALG_SECTOR_ERASE) ? 3'h6 : 3'h1);               // see R6
      busy <= 1'b1;
    end
    else if (!busy && do_read)
    begin
      taddr <= target_addr;
      busy <= 1'b1;
      reading <= 1'b1;
      total <= '0;
    end
    else if (busy && reading)
    begin
      if (bus.rvalid || bus.err)
      begin
        busy <= 1'b0;
        reading <= 1'b0;
      end
    end
    else if (busy)
    begin
      step <= step + 3'h1;
      if (step + 3'h1 == total)
        busy <= 1'b0;
    end
  end

  // Bus drive: every command write is a half-word
  always_comb
  begin
    bus.req = busy && !(reading && step == 3'h7);
    bus.write = busy && !reading;
    bus.size = (reading && word_read) ? WIDTH_READ_ONLY : WIDTH_PROGRAM; // see R14
    bus.addr = taddr;
    bus.wdata = 16'h0000;
    if (busy && !reading)
    begin
      if (single)
        bus.wdata = {8'h00, single_byte};                          // see R7 see R11 see R12
      else if (last_data)
        bus.wdata = tdata;                                         // see R21
      else
      begin
        bus.wdata = {8'h00, dbyte[step]};                          // see R9
        if (!sect_last)
          bus.addr = {base_hi, aseq[step]};
      end
    end
  end

  // Read result capture
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      read_data <= '0;
      read_done <= 1'b0;
    end
    else
    begin
      read_done <= reading && bus.rvalid;
      if (reading && bus.rvalid)
        read_data <= bus.rdata;
    end
  end
endmodule // flash_cmd_host

// ---- bench/flash_mode_and_command_decoder_chk.sv ----
/*
  Checker on the flash bus carrier and the mode and start outputs.
  Assumes one clock and a synchronous active-high reset.
*/
module flash_mode_and_command_decoder_chk
  import flash_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic req,
  input wire logic write,
  input wire logic [1:0] size,
  input wire logic [31:0] addr,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic err,
  input wire logic [1:0] access_width_field,
  input wire logic alg_start,
  input alg_t alg_kind
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Width field back to read-only once reset drops
  reset_width_a:
    assert property ($fell(reset) |-> access_width_field == WIDTH_RESET)
    else $error("width field not read-only after reset");
  // Algorithms start only out of programming mode
  ro_no_start_a:
    assert property (alg_start |-> $past(access_width_field) == WIDTH_PROGRAM)
    else $error("start outside programming mode");
  // Writes in read-only mode are refused
  ro_write_err_a:
    assert property (req && write && access_width_field == WIDTH_READ_ONLY |=> err)
    else $error("read-only write not refused");
  // Word reads refused in programming mode
  pm_word_err_a:
    assert property (req && !write && size == 2'h2 && access_width_field == WIDTH_PROGRAM
      |=> err && !rvalid)
    else $error("word read allowed in programming mode");
  // Word reads in range served in read-only mode
  ro_word_ok_a:
    assert property (req && !write && size == 2'h2 && access_width_field == WIDTH_READ_ONLY
      && addr[31:16] <= RANGE_HIGH_HI |=> rvalid && !err)
    else $error("word read refused in read-only mode");
  // Every read answered exactly once next cycle
  read_answer_a:
    assert property (req && !write |=> rvalid ^ err)
    else $error("read answer missing or doubled");
  // Half-word reads carry a zero upper half
  half_upper_a:
    assert property (req && !write && size == 2'h1 |=> !rvalid || rdata[31:16] == 16'h0000)
    else $error("half read upper bits not zero");
  // Out-of-range accesses refused
  out_range_a:
    assert property (req && addr[31:16] > RANGE_HIGH_HI |=> err)
    else $error("out of range access not refused");
  // Program start follows an even-address write
  prog_even_a:
    assert property (alg_start && alg_kind == ALG_PROGRAM |-> $past(req) && $past(write)
      && !$past(addr[0]))
    else $error("program start without even data write");
  cover property (alg_start && alg_kind == ALG_PROGRAM);
  cover property (alg_start && alg_kind == ALG_CHIP_ERASE);
  cover property (alg_start && alg_kind == ALG_SECTOR_ERASE);
  cover property (err);
endmodule // flash_mode_and_command_decoder_chk

// ---- bench/flash_mode_and_command_decoder_test.sv ----
/*
  Bench: host driver and flash front end joined by the carrier.
  Assumes a 40 ns clock and a shortened sector queue window.
*/
module flash_mode_and_command_decoder_test
  import flash_cmd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WIN = 16; // Short queue window
  // Expected start: kind, optional target
  typedef struct {alg_t k; logic ck; logic [31:0] a; logic [15:0] d;} note_t;
  logic clk, reset, start, do_read, word_read, width_we;
  logic busy, read_done, alg_start, erase_pending;
  alg_t kind, alg_kind;
  logic [31:0] target_addr, read_data, alg_addr, a;
  logic [15:0] target_data, alg_data, d0, d1;
  logic [1:0] width_wdata, access_width_field;
  int miscompares, check_count;
  note_t alg_q[$]; // Expected starts
  logic [31:0] rd_q[$]; // Expected read data
  flash_bus_if flash_bus_if_i ();
  flash_cmd_device #(.WINDOW_CYCLES(WIN)) flash_cmd_device_i (.clk(clk), .reset(reset),
    .bus(flash_bus_if_i.device), .width_wdata(width_wdata), .width_we(width_we),
    .access_width_field(access_width_field), .alg_start(alg_start), .alg_kind(alg_kind),
    .alg_addr(alg_addr), .alg_data(alg_data), .erase_pending(erase_pending));
  flash_cmd_host flash_cmd_host_i (.clk(clk), .reset(reset), .bus(flash_bus_if_i.host),
    .start(start), .kind(kind), .do_read(do_read), .word_read(word_read),
    .target_addr(target_addr), .target_data(target_data), .busy(busy),
    .read_data(read_data), .read_done(read_done));
  flash_mode_and_command_decoder_chk flash_mode_and_command_decoder_chk_i (.clk(clk),
    .reset(reset), .req(flash_bus_if_i.req), .write(flash_bus_if_i.write),
    .size(flash_bus_if_i.size), .addr(flash_bus_if_i.addr), .rdata(flash_bus_if_i.rdata),
    .rvalid(flash_bus_if_i.rvalid), .err(flash_bus_if_i.err),
    .access_width_field(access_width_field), .alg_start(alg_start), .alg_kind(alg_kind));
  // Clock, 40 ns
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and stop
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Bounded wait for the host to finish
  task automatic wait_idle();
    int i;
    for (i = 0; i < 50; i++)
    begin
      @(negedge clk);
      if (busy === 1'b0)
        break;
    end
    if (i == 50)
    begin
      miscompares++;
      end_sim();
    end
    repeat (6) @(posedge clk);
  endtask
  // Write the access-width field
  task automatic setw(input logic [1:0] w);
    @(posedge clk);
    width_wdata <= w;
    width_we <= 1'b1;
    @(posedge clk);
    width_we <= 1'b0;
    @(negedge clk);
    check(access_width_field, w);
  endtask
  // Issue one command, noting its start if one is due
  task automatic cmd(input alg_t k, input logic [31:0] ta, input logic [15:0] td, input bit ok);
    if (ok)
      alg_q.push_back('{k, k == ALG_PROGRAM || k == ALG_SECTOR_ERASE, ta,
        (k == ALG_PROGRAM) ? td : {8'h00, CMD_SECTOR_ERASE}});
    @(posedge clk);
    kind <= k;
    target_addr <= ta;
    target_data <= td;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wait_idle();
  endtask
  // One read, noting its data if it should be served
  task automatic rd(input logic [31:0] ta, input logic w, input logic [31:0] e, input bit ok);
    if (ok)
      rd_q.push_back(e);
    @(posedge clk);
    target_addr <= ta;
    word_read <= w;
    do_read <= 1'b1;
    @(posedge clk);
    do_read <= 1'b0;
    wait_idle();
  endtask
  // Result watcher: pairs each start or read with the oldest note
  always @(negedge clk)
  begin
    note_t n;
    if (!reset && alg_start === 1'b1)
    begin
      if (alg_q.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        n = alg_q.pop_front();
        check(alg_kind, n.k);
        if (n.ck)
        begin
          check(alg_addr, n.a);
          check(alg_data, n.d);
        end
      end
    end
    if (!reset && read_done === 1'b1)
    begin
      if (rd_q.size() == 0)
        check(32'h1, 32'h0);
      else
        check(read_data, rd_q.pop_front());
    end
  end
  // Main sequence
  initial
  begin
    reset = 1'b1;
    start = 1'b0;
    do_read = 1'b0;
    word_read = 1'b0;
    width_we = 1'b0;
    width_wdata = 2'h0;
    kind = ALG_NONE;
    target_addr = 32'h0000_0000;
    target_data = 16'h0000;
    miscompares = 0;
    check_count = 0;
    void'($urandom(32'hbf57));
    a = $urandom_range(1023, 2) << 2;
    d0 = 16'($urandom);
    d1 = 16'($urandom);
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check(access_width_field, WIDTH_READ_ONLY);
    cmd(ALG_PROGRAM, a, d0, 1'b0);
    setw(WIDTH_PROGRAM);
    cmd(ALG_PROGRAM, a, d0, 1'b1);
    cmd(ALG_PROGRAM, a + 32'h2, d1, 1'b1);
    rd(a + 32'h2, 1'b0, {16'h0000, d1}, 1'b1);
    rd(a, 1'b1, 32'h0, 1'b0);
    setw(WIDTH_READ_ONLY);
    rd(a, 1'b1, {d1, d0}, 1'b1);
    rd(a, 1'b0, 32'h0, 1'b0);
    setw(WIDTH_PROGRAM);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check(access_width_field, WIDTH_READ_ONLY);
    setw(WIDTH_PROGRAM);
    cmd(ALG_PROGRAM, a + 32'h1, d0, 1'b0);
    cmd(ALG_PROGRAM, 32'h0011_0000, d0, 1'b0);
    cmd(ALG_PROGRAM, SECURITY_BASE, d0, 1'b1);
    cmd(ALG_PROGRAM, TRIM_BASE, d1, 1'b1);
    cmd(ALG_READ_RESET, a, d0, 1'b1);
    cmd(ALG_SUSPEND, a, d0, 1'b1);
    cmd(ALG_RESTART, a, d0, 1'b1);
    cmd(ALG_CHIP_ERASE, a, d0, 1'b1);
    cmd(ALG_SECTOR_ERASE, 32'h0000_4000, d0, 1'b1);
    @(negedge clk);
    check(erase_pending, 1'b1);
    alg_q.push_back('{ALG_SECTOR_ERASE, 1'b0, 32'h0, 16'h0});
    cmd(ALG_RESTART, 32'h0000_8000, d0, 1'b0);
    repeat (WIN + 4) @(posedge clk);
    @(negedge clk);
    check(erase_pending, 1'b0);
    cmd(ALG_RESTART, a, d0, 1'b1);
    cmd(ALG_SECTOR_ERASE, 32'h0000_4000, d0, 1'b1);
    cmd(ALG_READ_RESET, a, d0, 1'b1);
    @(negedge clk);
    check(erase_pending, 1'b0);
    repeat (10) @(posedge clk);
    check(alg_q.size(), 32'h0);
    check(rd_q.size(), 32'h0);
    end_sim();
  end
endmodule // flash_mode_and_command_decoder_test
